/* ps_loader_pkg.sv */
/*
 * package for the passive serial configuration loader: state encoding,
 * timing constants and the pin carrier structs.
 * assumes a 100 MHz system clock.
 */
package ps_loader_pkg;

	localparam int clock_mhz = 100;

	// restart low to done and status low, longest time in ns
	localparam int restart_to_low_ns = 1000;
	localparam int restart_to_low_cycles = (restart_to_low_ns * clock_mhz) / 1000;

	// status low pulse, least time in ns
	localparam int status_low_ns = 2500;
	localparam int status_low_cycles = (status_low_ns * clock_mhz + 999) / 1000;

	// initialization length in configuration clock cycles
	localparam int init_cycles = 10;

	// configuration size in bits
	localparam int config_bits_default = 4096;

	localparam logic [2:0] bit_index_reset = 3'h0;
	localparam logic [7:0] byte_reset = 8'h00;

	typedef enum logic [2:0] {
		st_restart,
		st_status_hold,
		st_receive,
		st_init,
		st_user
	} loader_state_type;

	// pins driven by the host
	typedef struct packed {
		logic serial_clock;
		logic serial_data;
		logic restart_n;
	} host_pins_type;

	// pins driven by the device
	typedef struct packed {
		logic done_flag;
		logic status_n;
		logic data_out;
		logic data_oe_n;
	} device_pins_type;

endpackage : ps_loader_pkg

/* pin_sync.sv */
/*
 * two flip-flop synchroniser for a group of pins from outside the clock domain.
 * assumes inputs are asynchronous to clock.
 */
`timescale 1ns/1ps
module pin_sync #(
	parameter int width = 3
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// pins
	input wire logic [width-1:0] async_in,
	output logic [width-1:0] sync_out
);
	logic [width-1:0] stage1;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			stage1 <= '0;
			sync_out <= '0;
		end else begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end

endmodule : pin_sync

/* byte_shifter.sv */
/*
 * lsb-first serial to byte assembler.
 * assumes shift is a one-cycle pulse per captured bit, clear a level.
 */
`timescale 1ns/1ps
module byte_shifter
	import ps_loader_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// control
	input wire logic clear,
	input wire logic shift,
	input wire logic bit_in,
	// result
	output logic [7:0] byte_out,
	output logic byte_valid
);
	logic [2:0] bit_index;
	logic [7:0] shift_reg;
	wire [7:0] next_shift = {bit_in, shift_reg[7:1]};
	wire last_bit = (bit_index == 3'h7);

	always_ff @(posedge clock) begin
		if (!rst_n || clear) begin
			bit_index <= bit_index_reset;
			shift_reg <= byte_reset;
			byte_out <= byte_reset;
			byte_valid <= 1'b0;
		end else begin
			byte_valid <= shift && last_bit;
			if (shift) begin
				shift_reg <= next_shift;
				bit_index <= bit_index + 3'h1;
				if (last_bit)
					byte_out <= next_shift;
			end
		end
	end

endmodule : byte_shifter

/* passive_serial_config_loader.sv */
/*
 * slave side loader for passive serial configuration with restart control.
 * assumes a host shifting bits on the serial clock at 2 MHz or less and
 * an external pull-up on the status and done pins.
 */
// Behaviour
// - host pulses serial clock high; device captures data on rising edge
// - host shifts until done; done rises only after full configuration
// - restart falling pulls done and status low within 1 us
// - status stays low at least 2.5 us during restart
// - serial data pin is input only until user mode
// - a low-high restart pulse resets device from any state
// - no configuration starts while restart stays low
// - reconfiguration discards all user state
// - after restart device waits for host bits, never fetches itself
// - done rises only after initialization finishes
// - initialization lasts 10 serial clock cycles before user mode
`timescale 1ns/1ps
module passive_serial_config_loader
	import ps_loader_pkg::*;
#(
	parameter int config_bits = config_bits_default
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// configuration pins from the host
	input ps_loader_pkg::host_pins_type host_pins,
	// user mode drive for the shared data pin
	input wire logic user_data_out,
	input wire logic user_data_drive,
	// configuration pins to the host
	output ps_loader_pkg::device_pins_type device_pins,
	// configuration stream
	output logic [7:0] config_byte,
	output logic config_byte_valid,
	output logic user_mode
);
	import ps_loader_pkg::*;

	localparam int count_width = $clog2(config_bits + 1);

	logic [2:0] pins_sync;
	logic clock_prev;
	loader_state_type state;
	logic [count_width-1:0] bit_count;
	logic [3:0] init_count;
	logic [$clog2(status_low_cycles + 1)-1:0] hold_count;
	logic [7:0] shifted_byte;
	logic shifted_valid;

	pin_sync #(
		.width(3)
	) sync_inst (
		.clock(clock),
		.rst_n(rst_n),
		.async_in({host_pins.serial_clock, host_pins.serial_data, host_pins.restart_n}),
		.sync_out(pins_sync)
	);

	wire serial_clock_s = pins_sync[2];
	wire serial_data_s = pins_sync[1];
	wire restart_n_s = pins_sync[0];
	wire clock_rise = serial_clock_s && !clock_prev;
	wire restart_low = !restart_n_s;
	wire receiving = (state == st_receive);
	wire last_bit = (bit_count == count_width'(config_bits - 1));
	wire init_last = (init_count == 4'(init_cycles - 1));
	wire hold_done = (hold_count >= ($bits(hold_count))'(status_low_cycles));
	wire shift_bit = receiving && clock_rise;
	wire clear_shifter = restart_low;

	byte_shifter shifter_inst (
		.clock(clock),
		.rst_n(rst_n),
		.clear(clear_shifter),
		.shift(shift_bit),
		.bit_in(serial_data_s),
		.byte_out(shifted_byte),
		.byte_valid(shifted_valid)
	);

	// next state: restart dominates every state
	loader_state_type next_state;
	always_comb begin
		next_state = state;
		if (restart_low) begin
			next_state = st_restart;
		end else begin
			unique case (state)
				st_restart: next_state = st_status_hold;
				st_status_hold: if (hold_done) next_state = st_receive;
				st_receive: if (clock_rise && last_bit) next_state = st_init;
				st_init: if (clock_rise && init_last) next_state = st_user;
				st_user: next_state = st_user;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state <= st_restart;
			clock_prev <= 1'b0;
		end else begin
			state <= next_state;
			clock_prev <= serial_clock_s;
		end
	end

	// counters, all cleared by restart
	always_ff @(posedge clock) begin
		if (!rst_n || restart_low) begin
			bit_count <= '0;
			init_count <= 4'h0;
			hold_count <= '0;
		end else begin
			if (state == st_status_hold && !hold_done)
				hold_count <= hold_count + 1'b1;
			if (shift_bit)
				bit_count <= bit_count + 1'b1;
			if (state == st_init && clock_rise)
				init_count <= init_count + 4'h1;
		end
	end

	// pin and stream outputs, all registered
	wire in_user = (next_state == st_user);
	wire status_low = (next_state == st_restart) || (next_state == st_status_hold);
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			device_pins.done_flag <= 1'b0;
			device_pins.status_n <= 1'b0;
			device_pins.data_out <= 1'b0;
			device_pins.data_oe_n <= 1'b1;
			config_byte <= byte_reset;
			config_byte_valid <= 1'b0;
			user_mode <= 1'b0;
		end else begin
			device_pins.done_flag <= in_user;
			device_pins.status_n <= !status_low;
			device_pins.data_out <= in_user && user_data_out;
			device_pins.data_oe_n <= !(in_user && user_data_drive);
			config_byte <= restart_low ? byte_reset : shifted_byte;
			config_byte_valid <= shifted_valid && !restart_low;
			user_mode <= in_user;
		end
	end

	// restart low seen at the pins reaches done and status within 1 us
	int restart_age;
	always_ff @(posedge clock) begin
		if (!rst_n || host_pins.restart_n)
			restart_age <= 0;
		else if (restart_age < 1000)
			restart_age <= restart_age + 1;
	end

	restart_done_a: assert property (@(posedge clock) disable iff (!rst_n)
		(restart_age >= restart_to_low_cycles) |-> !device_pins.done_flag)
		else $error("done flag still high 1 us after restart");

	restart_status_a: assert property (@(posedge clock) disable iff (!rst_n)
		(restart_age >= restart_to_low_cycles) |-> !device_pins.status_n)
		else $error("status still high 1 us after restart");

	// status low pulse length
	int status_low_run;
	always_ff @(posedge clock) begin
		if (!rst_n || device_pins.status_n)
			status_low_run <= 0;
		else if (status_low_run < 1000)
			status_low_run <= status_low_run + 1;
	end

	status_pulse_a: assert property (@(posedge clock) disable iff (!rst_n)
		$rose(device_pins.status_n) |-> ($past(status_low_run) >= status_low_cycles))
		else $error("status low pulse shorter than 2.5 us");

	no_start_low_a: assert property (@(posedge clock) disable iff (!rst_n)
		restart_low |=> (state == st_restart))
		else $error("loader left restart while restart held low");

	data_input_a: assert property (@(posedge clock) disable iff (!rst_n)
		!user_mode |-> device_pins.data_oe_n)
		else $error("data pin driven outside user mode");

	done_after_init_a: assert property (@(posedge clock) disable iff (!rst_n)
		$rose(device_pins.done_flag) |-> $past(state) == st_init)
		else $error("done rose without finishing initialization");

	// serial clock rises seen in initialization, apart from the design's counter
	int init_rises;
	always_ff @(posedge clock) begin
		if (!rst_n || state != st_init)
			init_rises <= 0;
		else if (clock_rise && init_rises < 1000)
			init_rises <= init_rises + 1;
	end

	init_length_a: assert property (@(posedge clock) disable iff (!rst_n)
		(state == st_init && next_state == st_user) |->
			(init_count == 4'(init_cycles - 1)) && (init_rises == init_cycles - 1))
		else $error("initialization length wrong");

	clear_partial_a: assert property (@(posedge clock) disable iff (!rst_n)
		restart_low |=> (bit_count == '0) && (init_count == 4'h0))
		else $error("restart did not clear counters");

	lsb_first_a: assert property (@(posedge clock) disable iff (!rst_n)
		config_byte_valid |-> (config_byte[7] == $past(serial_data_s, 2)))
		else $error("last captured bit not in byte msb");

	// cycles spent in status hold, apart from the design's counter
	int hold_run;
	always_ff @(posedge clock) begin
		if (!rst_n || state != st_status_hold)
			hold_run <= 0;
		else if (hold_run < 1000)
			hold_run <= hold_run + 1;
	end

	hold_length_a: assert property (@(posedge clock) disable iff (!rst_n)
		(state == st_status_hold && next_state == st_receive) |-> (hold_run >= status_low_cycles))
		else $error("status hold left too early");

	// bytes handed over since the last restart
	int bytes_seen;
	always_ff @(posedge clock) begin
		if (!rst_n || restart_low)
			bytes_seen <= 0;
		else if (config_byte_valid && bytes_seen < 1000)
			bytes_seen <= bytes_seen + 1;
	end

	bytes_count_a: assert property (@(posedge clock) disable iff (!rst_n)
		$rose(user_mode) |-> (bytes_seen == config_bits / 8))
		else $error("user mode reached before all bytes arrived");

	status_restart_a: assert property (@(posedge clock) disable iff (!rst_n)
		restart_low |=> !device_pins.status_n)
		else $error("status not pulled low by restart");

	done_restart_a: assert property (@(posedge clock) disable iff (!rst_n)
		restart_low |=> !device_pins.done_flag)
		else $error("done not pulled low by restart");

	restart_exit_a: assert property (@(posedge clock) disable iff (!rst_n)
		(state == st_restart && !restart_low) |=> (state == st_status_hold))
		else $error("restart release did not start status hold");

	hold_to_receive_a: assert property (@(posedge clock) disable iff (!rst_n)
		(state == st_status_hold && hold_done && !restart_low) |=> (state == st_receive))
		else $error("status hold did not lead to receiving");

	status_release_a: assert property (@(posedge clock) disable iff (!rst_n)
		$rose(device_pins.status_n) |-> (state == st_receive))
		else $error("status released outside receiving");

	bit_bound_a: assert property (@(posedge clock) disable iff (!rst_n)
		bit_count <= count_width'(config_bits))
		else $error("bit counter beyond configuration size");

	valid_one_cycle_a: assert property (@(posedge clock) disable iff (!rst_n)
		config_byte_valid |=> !config_byte_valid)
		else $error("byte valid longer than one cycle");

	restart_valid_a: assert property (@(posedge clock) disable iff (!rst_n)
		restart_low |=> !config_byte_valid)
		else $error("byte handed over while restart low");

	restart_byte_a: assert property (@(posedge clock) disable iff (!rst_n)
		restart_low |=> (config_byte == byte_reset) && !user_mode)
		else $error("user state kept through restart");

	shifter_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
		restart_low |=> (shifted_byte == byte_reset) && !shifted_valid)
		else $error("partial byte kept through restart");

	restart_hold_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
		restart_low |=> (hold_count == '0))
		else $error("hold counter kept through restart");

	done_fall_a: assert property (@(posedge clock) disable iff (!rst_n)
		$fell(device_pins.done_flag) |-> $past(restart_low))
		else $error("done fell without restart");

	user_stays_a: assert property (@(posedge clock) disable iff (!rst_n)
		(state == st_user && !restart_low) |=> (state == st_user))
		else $error("user mode left without restart");

	done_user_a: assert property (@(posedge clock) disable iff (!rst_n)
		device_pins.done_flag |-> user_mode)
		else $error("done high outside user mode");

	init_no_shift_a: assert property (@(posedge clock) disable iff (!rst_n)
		(state == st_init && !restart_low) |=> $stable(bit_count))
		else $error("bits counted during initialization");

	data_quiet_a: assert property (@(posedge clock) disable iff (!rst_n)
		!user_mode |-> !device_pins.data_out)
		else $error("data output value outside user mode");

	oe_released_a: assert property (@(posedge clock) disable iff (!rst_n)
		$fell(user_mode) |-> device_pins.data_oe_n)
		else $error("data pin still driven after leaving user mode");

endmodule : passive_serial_config_loader

/* ps_host_model.sv */
/* host model: drives restart and clocks serial bits into the loader.
 * assumes each task is called just after a rising edge of the system clock. */
`timescale 1ns/1ps
module ps_host_model #(
	parameter int half_ns = 250
) (
	// pins to the device
	output ps_loader_pkg::host_pins_type pins
);
	import ps_loader_pkg::*;

	// clock stands low and restart is pulled up outside frames
	initial begin
		pins = '{1'b0, 1'b0, 1'b1};
	end

	task automatic pulse(input logic b);
		#3 pins.serial_data = b;
		#(half_ns) pins.serial_clock = 1'b1;
		#(half_ns) pins.serial_clock = 1'b0;
		pins.serial_data = ~b;
		#(half_ns);
	endtask : pulse

	task automatic drive_restart(input logic level);
		#3 pins.restart_n = level;
		if (level) begin
			#5000;
		end
	endtask : drive_restart
endmodule : ps_host_model

/* passive_serial_config_loader_test.sv */
/* self-checking bench for the passive serial loader.
 * assumes the design answers restart within 100 cycles and holds status 250. */
`timescale 1ns/1ps
module passive_serial_config_loader_test;
	import ps_loader_pkg::*;
	localparam int cfg_bits = 16;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic user_data_out = 1'b0;
	logic user_data_drive = 1'b0;
	host_pins_type host_pins;
	device_pins_type device_pins;
	logic [7:0] config_byte;
	logic config_byte_valid;
	logic user_mode;
	logic [7:0] got_q[$];
	logic [15:0] seed = 16'h0f64;
	int mismatches = 0;
	int cmp_count = 0;
	int cycles = 0;
	int low_run = 0;

	always #5 clock = ~clock;

	ps_host_model u_ps_host_model (.pins(host_pins));
	passive_serial_config_loader #(.config_bits(cfg_bits)) u_passive_serial_config_loader (
		.clock(clock), .rst_n(rst_n), .host_pins(host_pins),
		.user_data_out(user_data_out), .user_data_drive(user_data_drive),
		.device_pins(device_pins), .config_byte(config_byte),
		.config_byte_valid(config_byte_valid), .user_mode(user_mode));

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : print_verdict

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
			mismatches++;
		end
	endtask : check

	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr_next

	task automatic send_byte(input logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			@(posedge clock);
			u_ps_host_model.pulse(b[i]);
		end
	endtask : send_byte

	task automatic do_restart();
		@(posedge clock);
		u_ps_host_model.drive_restart(1'b0);
		got_q.delete();
		repeat (100) @(posedge clock);
		#1;
		check({6'h0, device_pins.done_flag, device_pins.status_n}, 8'h00);
		send_byte(8'hff);
		repeat (100) @(posedge clock);
		#1;
		check({7'h0, user_mode}, 8'h00);
		check(config_byte, 8'h00);
		@(posedge clock);
		u_ps_host_model.drive_restart(1'b1);
		check(8'(got_q.size()), 8'h00);
	endtask : do_restart

	// random bytes are shifted in and compared as each one lands
	task automatic config_frame();
		logic [7:0] b;
		for (int k = 0; k < cfg_bits / 8; k++) begin
			seed = lfsr_next(seed);
			b = seed[7:0];
			send_byte(b);
			repeat (8) @(posedge clock);
			check(got_q.size() > k ? got_q[k] : 8'hxx, b);
		end
		check({6'h0, device_pins.done_flag, device_pins.data_oe_n}, 8'h01);
		for (int i = 0; i < init_cycles; i++) begin
			check({6'h0, device_pins.done_flag, user_mode}, 8'h00);
			@(posedge clock);
			u_ps_host_model.pulse(1'b0);
		end
		repeat (8) @(posedge clock);
		#1;
		check({6'h0, device_pins.done_flag, user_mode}, 8'h03);
	endtask : config_frame

	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (rst_n && device_pins.status_n === 1'b0) begin
			low_run <= low_run + 1;
		end else begin
			if (rst_n && low_run > 0)
				check({7'h0, low_run >= status_low_cycles}, 8'h01);
			low_run <= 0;
		end
		if (config_byte_valid === 1'b1)
			got_q.push_back(config_byte);
		if (cycles == 20000) begin
			mismatches++;
			print_verdict();
		end
	end

	initial begin
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		do_restart();
		config_frame();
		for (int i = 0; i < 6; i++) begin
			seed = lfsr_next(seed);
			@(posedge clock);
			user_data_out <= seed[0];
			user_data_drive <= seed[1];
			repeat (3) @(posedge clock);
			#1;
			check({6'h0, device_pins.data_oe_n, device_pins.data_out & seed[1]},
				{6'h0, ~seed[1], seed[0] & seed[1]});
		end
		// restart from user mode, then a partial byte cut short by another restart
		do_restart();
		for (int i = 0; i < 3; i++) begin
			@(posedge clock);
			u_ps_host_model.pulse(1'b1);
		end
		do_restart();
		config_frame();
		print_verdict();
	end
endmodule : passive_serial_config_loader_test
